/* hw/addc_pkg.sv */
package addc_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDC_OFS_CTRL = 8'h00;
  localparam logic [7:0] ADDC_OFS_TUNE0 = 8'h04;
  localparam logic [7:0] ADDC_OFS_TUNE1 = 8'h08;
  localparam logic [7:0] ADDC_OFS_DEC0 = 8'h0C;
  localparam logic [7:0] ADDC_OFS_DEC1 = 8'h10;
  localparam logic [7:0] ADDC_OFS_COEF0 = 8'h14;
  localparam logic [7:0] ADDC_OFS_COEF1 = 8'h18;
  localparam logic [7:0] ADDC_OFS_STATUS = 8'h1C;
  localparam logic [7:0] ADDC_OFS_DESC0 = 8'h20;
  localparam logic [7:0] ADDC_OFS_DESC1 = 8'h24;
  localparam logic [7:0] ADDC_OFS_DESC2 = 8'h28;
  localparam logic [7:0] ADDC_OFS_DESC3 = 8'h2C;
  // Control field positions
  localparam int ADDC_CTRL_SRC0 = 0;
  localparam int ADDC_CTRL_SRC1 = 2;
  localparam int ADDC_CTRL_OUT16_0 = 4;
  localparam int ADDC_CTRL_OUT16_1 = 5;
  localparam int ADDC_CTRL_CAPTURE = 6;
  localparam int ADDC_CTRL_GATEMODE = 7;
  localparam int ADDC_CTRL_META = 8;
  localparam int ADDC_CTRL_START = 9;
  localparam int ADDC_CTRL_CHAN_ID = 12;
  // Descriptor field positions
  localparam int ADDC_DESC_NEXT = 10;
  localparam int ADDC_DESC_LAST = 12;
  // Coefficient write fields
  localparam int ADDC_COEF_IDX = 16;
  // Source selector codes
  localparam logic [1:0] ADDC_SRC_ADC0 = 2'h0;
  localparam logic [1:0] ADDC_SRC_ADC1 = 2'h1;
  // Reset values
  localparam logic [31:0] ADDC_CTRL_RST = 32'h0000_0004;
  localparam logic [31:0] ADDC_TUNE_RST = 32'h0000_0000;
  localparam logic [17:0] ADDC_DEC_RST = 18'h00002;
  localparam logic [17:0] ADDC_DEC_MIN = 18'h00002;
  localparam logic [17:0] ADDC_DEC_MAX = 18'h20000;
  localparam logic [15:0] ADDC_COEF_RST = 16'h4000;
  localparam logic [31:0] ADDC_DESC_RST = 32'h0000_1010;
  // Sizes
  localparam int ADDC_NDDC = 2;
  localparam int ADDC_NTAP = 16;
  localparam int ADDC_MEM_DEPTH = 64;
  localparam int ADDC_OUT_LSB = 14;
  localparam logic [31:0] ADDC_META_TAG = 32'hA0D0_0000;
  typedef enum {ADDC_IDLE, ADDC_LOAD, ADDC_META, ADDC_DATA, ADDC_NEXT} addc_dma_t;
endpackage

/* hw/addc_top.sv */
`timescale 1ns/1ps
// What this block does
// - Input selector: ADC0, ADC1 or test generator
// - One ADC feeds both, or one each
// - Memory bank runs as FIFO or capture
// - DMA walks linked descriptor list to host
// - Gate mode: transfer length from gate duration
// - Optional metadata: channel, time stamp, length
// - Independent 32-bit tuning word per downconverter
// - Decimation per downconverter, 2 to 131072
// - Each filter loads own 16-bit coefficients
// - Default coefficients give passband and rejection
// - Output 24+24 or 16+16 bits at fs/N
module addc_top (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic [11:0] i_adc0_data,
  input wire logic [11:0] i_adc1_data,
  input wire logic i_gate,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic o_ddc0_valid,
  output logic [23:0] o_ddc0_i,
  output logic [23:0] o_ddc0_q,
  output logic o_ddc1_valid,
  output logic [23:0] o_ddc1_i,
  output logic [23:0] o_ddc1_q,
  input wire logic i_dma_ready,
  output logic o_dma_valid,
  output logic [31:0] o_dma_data,
  output logic o_dma_busy
);
  import addc_pkg::*;

  logic [31:0] ctrl_reg;
  logic [31:0] tune_reg [ADDC_NDDC];
  logic [17:0] dec_reg [ADDC_NDDC];
  logic [15:0] coef_reg [ADDC_NDDC][ADDC_NTAP];
  logic [31:0] desc_reg [4];
  logic [7:0] waddr_reg;
  logic wr_pend_reg;
  logic [31:0] rdata_reg;
  logic addr_phase;
  logic start_pulse;
  logic [11:0] test_reg;
  logic ddc_valid [ADDC_NDDC];
  logic [23:0] ddc_i [ADDC_NDDC];
  logic [23:0] ddc_q [ADDC_NDDC];
  logic [31:0] mem [ADDC_MEM_DEPTH];
  logic [6:0] wptr_reg;
  logic [6:0] rptr_reg;
  logic [6:0] level;
  logic mem_wr;
  logic mem_rd;
  logic gate_d_reg;
  logic cap_done_reg;
  logic gate_done_reg;
  logic [9:0] gate_cnt_reg;
  logic [9:0] gate_len_reg;
  logic [31:0] ts_reg;
  logic [31:0] ts_gate_reg;
  addc_dma_t state_reg;
  logic [1:0] cur_reg;
  logic [1:0] meta_idx_reg;
  logic [9:0] rem_reg;
  logic [9:0] len_reg;
  logic out_free;
  logic gate_fall;

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_reg;
  assign addr_phase = hsel && htrans[1] && hready && i_ce;
  assign start_pulse = wr_pend_reg && (waddr_reg == ADDC_OFS_CTRL) && hwdata[ADDC_CTRL_START];

  // Address phase capture; read data is staged here so hrdata is a flop
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      wr_pend_reg <= 1'b0;
      waddr_reg <= 8'h00;
      rdata_reg <= 32'h0000_0000;
    end else if (i_ce) begin
      wr_pend_reg <= addr_phase && hwrite;
      waddr_reg <= {haddr[7:2], 2'b00};
      if (addr_phase && !hwrite) begin
        case ({haddr[7:2], 2'b00})
          ADDC_OFS_CTRL: rdata_reg <= ctrl_reg;
          ADDC_OFS_TUNE0: rdata_reg <= tune_reg[0];
          ADDC_OFS_TUNE1: rdata_reg <= tune_reg[1];
          ADDC_OFS_DEC0: rdata_reg <= {14'h0000, dec_reg[0]};
          ADDC_OFS_DEC1: rdata_reg <= {14'h0000, dec_reg[1]};
          ADDC_OFS_STATUS: rdata_reg <= {4'h0, level, 4'h0, gate_done_reg, cap_done_reg,
                                         cur_reg, 2'h0, o_dma_busy, rem_reg};
          ADDC_OFS_DESC0, ADDC_OFS_DESC1, ADDC_OFS_DESC2, ADDC_OFS_DESC3:
            rdata_reg <= desc_reg[haddr[3:2]];
          default: rdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Register writes in the data phase; START is a self-clearing strobe
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      ctrl_reg <= ADDC_CTRL_RST;
      tune_reg <= '{default: ADDC_TUNE_RST};
      dec_reg <= '{default: ADDC_DEC_RST};
      desc_reg <= '{default: ADDC_DESC_RST};
    end else if (i_ce && wr_pend_reg) begin
      case (waddr_reg)
        ADDC_OFS_CTRL: ctrl_reg <= hwdata & ~(32'h1 << ADDC_CTRL_START);
        ADDC_OFS_TUNE0: tune_reg[0] <= hwdata;
        ADDC_OFS_TUNE1: tune_reg[1] <= hwdata;
        // decimation clamped
        // Channel picked by full offset compare against DEC1, not by a single address bit
        ADDC_OFS_DEC0, ADDC_OFS_DEC1: begin
          if (hwdata < {14'h0000, ADDC_DEC_MIN}) begin
            dec_reg[waddr_reg == ADDC_OFS_DEC1] <= ADDC_DEC_MIN;
          end else if (hwdata > {14'h0000, ADDC_DEC_MAX}) begin
            dec_reg[waddr_reg == ADDC_OFS_DEC1] <= ADDC_DEC_MAX;
          end else begin
            dec_reg[waddr_reg == ADDC_OFS_DEC1] <= hwdata[17:0];
          end
        end
        ADDC_OFS_DESC0, ADDC_OFS_DESC1, ADDC_OFS_DESC2, ADDC_OFS_DESC3:
          desc_reg[waddr_reg[3:2]] <= hwdata;
        default: ;
      endcase
    end
  end

  // coefficient load; reset values form the default filter
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      coef_reg <= '{default: '{default: ADDC_COEF_RST}};
    end else if (i_ce && wr_pend_reg) begin
      if (waddr_reg == ADDC_OFS_COEF0 || waddr_reg == ADDC_OFS_COEF1) begin
        coef_reg[waddr_reg == ADDC_OFS_COEF1][hwdata[ADDC_COEF_IDX+3:ADDC_COEF_IDX]] <= hwdata[15:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Test generator: a ramp, easy to recognise after mixing
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      test_reg <= 12'h000;
    end else if (i_ce) begin
      test_reg <= test_reg + 12'h001;
    end
  end

  // One downconverter per channel: selector, NCO mixer, decimating filter
  for (genvar g = 0; g < ADDC_NDDC; g++) begin : g_ddc
    logic [1:0] src;
    logic signed [12:0] x;
    logic signed [12:0] mix_i;
    logic signed [12:0] mix_q;
    logic [31:0] phase_reg;
    logic [17:0] cnt_reg;
    logic signed [47:0] acc_i_reg;
    logic signed [47:0] acc_q_reg;
    logic signed [47:0] sum_i;
    logic signed [47:0] sum_q;
    logic signed [15:0] c;
    logic out16;
    logic valid_reg;
    logic [23:0] i_reg;
    logic [23:0] q_reg;
    assign src = ctrl_reg[2*g+1:2*g];
    assign out16 = ctrl_reg[ADDC_CTRL_OUT16_0+g];
    // source select; each channel routes independently
    assign x = (src == ADDC_SRC_ADC0) ? {i_adc0_data[11], i_adc0_data} :
               (src == ADDC_SRC_ADC1) ? {i_adc1_data[11], i_adc1_data} :
               {test_reg[11], test_reg};
    // Coarse quadrant mixer; a fine LO table would cost block memory
    always_comb begin
      case (phase_reg[31:30])
        2'h0: begin mix_i = x; mix_q = 13'sd0; end
        2'h1: begin mix_i = 13'sd0; mix_q = -x; end
        2'h2: begin mix_i = -x; mix_q = 13'sd0; end
        default: begin mix_i = 13'sd0; mix_q = x; end
      endcase
    end
    assign c = coef_reg[g][cnt_reg[3:0]];
    // Widen before the product; a 16-bit product would lose the top bits
    assign sum_i = acc_i_reg + 48'(mix_i) * 48'(c);
    assign sum_q = acc_q_reg + 48'(mix_q) * 48'(c);
    always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
        phase_reg <= 32'h0000_0000;
      end else if (i_ce) begin
        phase_reg <= phase_reg + tune_reg[g];
      end
    end
    // dump every N inputs, strobe one cycle; output width
    always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
        cnt_reg <= 18'h00000;
        acc_i_reg <= 48'sd0;
        acc_q_reg <= 48'sd0;
        valid_reg <= 1'b0;
        i_reg <= 24'h000000;
        q_reg <= 24'h000000;
      end else if (i_ce) begin
        valid_reg <= 1'b0;
        if (cnt_reg >= dec_reg[g] - 18'h00001) begin
          cnt_reg <= 18'h00000;
          acc_i_reg <= 48'sd0;
          acc_q_reg <= 48'sd0;
          valid_reg <= 1'b1;
          if (out16) begin
            i_reg <= {{8{sum_i[ADDC_OUT_LSB+23]}}, sum_i[ADDC_OUT_LSB+23:ADDC_OUT_LSB+8]};
            q_reg <= {{8{sum_q[ADDC_OUT_LSB+23]}}, sum_q[ADDC_OUT_LSB+23:ADDC_OUT_LSB+8]};
          end else begin
            i_reg <= sum_i[ADDC_OUT_LSB+23:ADDC_OUT_LSB];
            q_reg <= sum_q[ADDC_OUT_LSB+23:ADDC_OUT_LSB];
          end
        end else begin
          cnt_reg <= cnt_reg + 18'h00001;
          acc_i_reg <= sum_i;
          acc_q_reg <= sum_q;
        end
      end
    end
    assign ddc_valid[g] = valid_reg;
    assign ddc_i[g] = i_reg;
    assign ddc_q[g] = q_reg;
  end

  assign o_ddc0_valid = ddc_valid[0];
  assign o_ddc0_i = ddc_i[0];
  assign o_ddc0_q = ddc_q[0];
  assign o_ddc1_valid = ddc_valid[1];
  assign o_ddc1_i = ddc_i[1];
  assign o_ddc1_q = ddc_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // Memory bank holds channel 0 as packed 16-bit I and Q
  assign level = wptr_reg - rptr_reg;
  assign gate_fall = gate_d_reg && !i_gate;
  // FIFO writes freely, or only while the gate is high in gate mode; capture only inside one gate
  assign mem_wr = ddc_valid[0] && (level != 7'(ADDC_MEM_DEPTH)) &&
                  (ctrl_reg[ADDC_CTRL_CAPTURE] ? (i_gate && !cap_done_reg) :
                   (!ctrl_reg[ADDC_CTRL_GATEMODE] || i_gate));
  assign out_free = !o_dma_valid || i_dma_ready;
  assign mem_rd = (state_reg == ADDC_DATA) && out_free && (level != 7'h00) &&
                  (rem_reg != 10'h000);

  always_ff @(posedge i_core_clk) begin
    if (i_ce && mem_wr) begin
      mem[wptr_reg[5:0]] <= {ddc_i[0][23:8], ddc_q[0][23:8]};
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      wptr_reg <= 7'h00;
    end else if (i_ce && mem_wr) begin
      wptr_reg <= wptr_reg + 7'h01;
    end
  end

  // Gate tracking; a new gate end beats a clear in the same cycle
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      gate_d_reg <= 1'b0;
      cap_done_reg <= 1'b0;
      gate_done_reg <= 1'b0;
      gate_cnt_reg <= 10'h000;
      gate_len_reg <= 10'h000;
      ts_reg <= 32'h0000_0000;
      ts_gate_reg <= 32'h0000_0000;
    end else if (i_ce) begin
      gate_d_reg <= i_gate;
      if (ddc_valid[0]) begin
        ts_reg <= ts_reg + 32'h0000_0001;
      end
      if (i_gate && !gate_d_reg) begin
        ts_gate_reg <= ts_reg;
        // A write in the opening cycle belongs to this gate too
        gate_cnt_reg <= {9'h000, mem_wr};
      end else if (mem_wr) begin
        gate_cnt_reg <= gate_cnt_reg + 10'h001;
      end
      // gate length latched at gate end
      if (gate_fall) begin
        gate_len_reg <= gate_cnt_reg;
        gate_done_reg <= 1'b1;
        cap_done_reg <= ctrl_reg[ADDC_CTRL_CAPTURE];
      end else begin
        if (state_reg == ADDC_LOAD && ctrl_reg[ADDC_CTRL_GATEMODE]) begin
          gate_done_reg <= 1'b0;
        end
        if (start_pulse) begin
          cap_done_reg <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // DMA engine walks descriptors starting at entry 0
  assign o_dma_busy = state_reg != ADDC_IDLE;

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      state_reg <= ADDC_IDLE;
      cur_reg <= 2'h0;
      meta_idx_reg <= 2'h0;
      rem_reg <= 10'h000;
      len_reg <= 10'h000;
      rptr_reg <= 7'h00;
      o_dma_valid <= 1'b0;
      o_dma_data <= 32'h0000_0000;
    end else if (i_ce) begin
      if (i_dma_ready) begin
        o_dma_valid <= 1'b0;
      end
      case (state_reg)
        ADDC_IDLE: begin
          if (start_pulse) begin
            cur_reg <= 2'h0;
            // Start drops stale words, so a transfer carries only fresh samples
            rptr_reg <= wptr_reg;
            state_reg <= ADDC_LOAD;
          end
        end
        // in gate mode wait for gate end, then take its length
        ADDC_LOAD: begin
          if (!ctrl_reg[ADDC_CTRL_GATEMODE] || gate_done_reg) begin
            len_reg <= ctrl_reg[ADDC_CTRL_GATEMODE] ? gate_len_reg : desc_reg[cur_reg][9:0];
            rem_reg <= ctrl_reg[ADDC_CTRL_GATEMODE] ? gate_len_reg : desc_reg[cur_reg][9:0];
            meta_idx_reg <= 2'h0;
            state_reg <= ctrl_reg[ADDC_CTRL_META] ? ADDC_META : ADDC_DATA;
          end
        end
        // three metadata words: tagged channel, time stamp, length
        ADDC_META: begin
          if (out_free) begin
            o_dma_valid <= 1'b1;
            case (meta_idx_reg)
              2'h0: o_dma_data <= ADDC_META_TAG | {28'h0000000, ctrl_reg[15:12]};
              2'h1: o_dma_data <= ctrl_reg[ADDC_CTRL_GATEMODE] ? ts_gate_reg : ts_reg;
              default: o_dma_data <= {22'h000000, len_reg};
            endcase
            meta_idx_reg <= meta_idx_reg + 2'h1;
            if (meta_idx_reg == 2'h2) begin
              state_reg <= ADDC_DATA;
            end
          end
        end
        ADDC_DATA: begin
          if (rem_reg == 10'h000) begin
            state_reg <= ADDC_NEXT;
          end else if (mem_rd) begin
            o_dma_valid <= 1'b1;
            o_dma_data <= mem[rptr_reg[5:0]];
            rptr_reg <= rptr_reg + 7'h01;
            rem_reg <= rem_reg - 10'h001;
          end
        end
        // follow the link or stop at the last entry
        ADDC_NEXT: begin
          if (desc_reg[cur_reg][ADDC_DESC_LAST]) begin
            state_reg <= ADDC_IDLE;
          end else begin
            cur_reg <= desc_reg[cur_reg][ADDC_DESC_NEXT+1:ADDC_DESC_NEXT];
            state_reg <= ADDC_LOAD;
          end
        end
        default: state_reg <= ADDC_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_meta_words;
    (state_reg == ADDC_META && out_free) ##1 (o_dma_valid && o_dma_data[31:16] == 16'hA0D0);
  endsequence

  a_src_adc1: assert property (ctrl_reg[1:0] == ADDC_SRC_ADC1 |->
    g_ddc[0].x == {i_adc1_data[11], i_adc1_data}) else $error("source select wrong");
  a_route_shared: assert property (ctrl_reg[1:0] == ctrl_reg[3:2] |->
    g_ddc[0].x == g_ddc[1].x) else $error("shared routing differs");
  a_fifo_bound: assert property (level <= 7'(ADDC_MEM_DEPTH))
    else $error("memory level over depth");
  a_dma_link: assert property (state_reg == ADDC_NEXT && i_ce &&
    !desc_reg[cur_reg][ADDC_DESC_LAST] |=> state_reg == ADDC_LOAD &&
    cur_reg == $past(desc_reg[cur_reg][11:10])) else $error("descriptor link not followed");
  a_gate_len: assert property (state_reg == ADDC_LOAD && i_ce &&
    ctrl_reg[ADDC_CTRL_GATEMODE] && gate_done_reg |=> rem_reg == $past(gate_len_reg))
    else $error("gate length not used");
  a_meta_len: assert property (state_reg == ADDC_META && meta_idx_reg == 2'h2 &&
    out_free && i_ce |=> o_dma_data == {22'h000000, $past(rem_reg)} && state_reg == ADDC_DATA)
    else $error("metadata length word wrong");
  a_meta_tag: assert property (state_reg == ADDC_META && meta_idx_reg == 2'h0 &&
    out_free && i_ce |-> s_meta_words) else $error("metadata tag missing");
  a_phase_step: assert property (i_ce |=>
    g_ddc[1].phase_reg == $past(g_ddc[1].phase_reg) + $past(tune_reg[1]))
    else $error("phase step wrong");
  a_dec_range: assert property (dec_reg[0] >= ADDC_DEC_MIN && dec_reg[0] <= ADDC_DEC_MAX)
    else $error("decimation out of range");
  a_out16_sign: assert property (o_ddc0_valid && ctrl_reg[ADDC_CTRL_OUT16_0] &&
    $past(ctrl_reg[ADDC_CTRL_OUT16_0]) |-> o_ddc0_i[23:15] inside {9'h000, 9'h1FF})
    else $error("16-bit output not sign extended");
  a_strobe_gap: assert property (o_ddc0_valid && i_ce |=> !o_ddc0_valid)
    else $error("strobe on adjacent cycles");
  a_strobe_cause: assert property (i_ce && g_ddc[0].cnt_reg == dec_reg[0] - 18'h00001
    |=> o_ddc0_valid ##1 !o_ddc0_valid) else $error("strobe not after N inputs");
endmodule // addc_top

/* verification/adc_acquisition_ddc_bench.sv */
`timescale 1ns/1ps
module adc_acquisition_ddc_bench;
  import addc_pkg::*;
  logic i_core_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_gate = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic slow = 1'b0;
  logic [11:0] lvl0 = 12'h000;
  logic [11:0] lvl1 = 12'h400;
  logic hreadyout, hresp, d0_v, d1_v, dma_ready, dma_valid, dma_busy;
  logic [31:0] hrdata, dma_data, rd;
  logic [23:0] d0_i, d0_q, d1_i, d1_q;
  logic [11:0] adc0, adc1;
  int bad_count = 0;
  int n_compared = 0;
  logic [31:0] words[$];

  always #12.5 i_core_clk = ~i_core_clk;

  addc_top addc_top_i (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_ce(1'b1),
    .i_adc0_data(adc0), .i_adc1_data(adc1), .i_gate(i_gate), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .o_ddc0_valid(d0_v),
    .o_ddc0_i(d0_i), .o_ddc0_q(d0_q), .o_ddc1_valid(d1_v), .o_ddc1_i(d1_i), .o_ddc1_q(d1_q),
    .i_dma_ready(dma_ready), .o_dma_valid(dma_valid), .o_dma_data(dma_data),
    .o_dma_busy(dma_busy));
  addc_far_model addc_far_model_i (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_slow(slow),
    .i_lvl0(lvl0), .i_lvl1(lvl1), .o_adc0_data(adc0), .o_adc1_data(adc1),
    .o_dma_ready(dma_ready));

  ////////////////////////////////////////////////////////////////////////////////
  // Verdict, reached from the main sequence or from an expired wait in wait_rdy, wait_v or collect
  task automatic stop_test();
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic timed_out();
    bad_count++;
    $display("BAD at %0t: wait expired got %h expected %h", $time, 1'b0, 1'b1);
    stop_test();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Non-zero result expected; anything unknown fails too
  task automatic chk_nz(input logic [31:0] got);
    n_compared++;
    if ((got === 32'h0) || ($isunknown(got))) begin
      bad_count++;
      $display("BAD at %0t: got %h expected %h", $time, got, 32'h1);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Bus cycles: hold each phase until hready is seen high at a rising edge
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge i_core_clk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) timed_out();
      @(posedge i_core_clk);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  // Let n decimated samples of one channel pass
  task automatic wait_v(input int ch, input int n);
    int k;
    k = 0;
    while (n > 0) begin
      @(posedge i_core_clk);
      k++;
      if (k > 20000) timed_out();
      if ((ch ? d1_v : d0_v) === 1'b1) n--;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rchk(ADDC_OFS_CTRL, ADDC_CTRL_RST);
    rchk(ADDC_OFS_DEC0, 32'h2);
    rchk(ADDC_OFS_DESC0, ADDC_DESC_RST);
    rchk(8'h40, 32'h0);
    bus(1'b1, ADDC_OFS_TUNE0, 32'h1234_5678);
    bus(1'b1, ADDC_OFS_TUNE1, 32'h9ABC_DEF0);
    rchk(ADDC_OFS_TUNE0, 32'h1234_5678);
    rchk(ADDC_OFS_TUNE1, 32'h9ABC_DEF0);
    bus(1'b1, ADDC_OFS_DEC0, 32'h0);
    bus(1'b1, ADDC_OFS_DEC1, 32'h0003_FFFF);
    rchk(ADDC_OFS_DEC0, 32'h2);
    rchk(ADDC_OFS_DEC1, 32'h0002_0000);
    bus(1'b1, ADDC_OFS_TUNE0, 32'h0);
    bus(1'b1, ADDC_OFS_TUNE1, 32'h0);
    $display("test regs done");
  endtask
  // Cycles between two valid pulses must equal the decimation factor
  task automatic period(input int ch, input int n);
    int k;
    wait_v(ch, 1);
    k = 0;
    do begin
      @(posedge i_core_clk);
      k++;
    end while ((ch ? d1_v : d0_v) !== 1'b1 && k < 300);
    chk(k, n);
  endtask
  task automatic t_decim();
    bus(1'b1, ADDC_OFS_DEC0, 32'h5);
    bus(1'b1, ADDC_OFS_DEC1, 32'h3);
    period(0, 5);
    period(1, 3);
    bus(1'b1, ADDC_OFS_DEC0, 32'h2);
    bus(1'b1, ADDC_OFS_DEC1, 32'h2);
    period(0, 2);
    period(1, 2);
    $display("test decim done");
  endtask
  // Converter 0 is silent, converter 1 carries a level
  task automatic t_route();
    bus(1'b1, ADDC_OFS_CTRL, 32'h0);
    wait_v(0, 40);
    chk(d0_i, 32'h0);
    chk(d1_i, 32'h0);
    bus(1'b1, ADDC_OFS_CTRL, 32'h1);
    wait_v(0, 40);
    chk_nz(d0_i);
    chk(d1_i, 32'h0);
    lvl1 <= 12'hC00;
    bus(1'b1, ADDC_OFS_CTRL, 32'h11);
    wait_v(0, 40);
    chk(d0_i[23:16], 32'hFF);
    $display("test route done");
  endtask
  task automatic t_coef();
    lvl1 <= 12'h400;
    for (int t = 0; t < ADDC_NTAP; t++) bus(1'b1, ADDC_OFS_COEF0, t << ADDC_COEF_IDX);
    bus(1'b1, ADDC_OFS_CTRL, 32'h5);
    wait_v(0, 40);
    chk({d0_i, 8'h0}, 32'h0);
    chk({d0_q, 8'h0}, 32'h0);
    chk_nz(d1_i);
    $display("test coef done");
  endtask
  // Collect host words until the engine goes idle
  task automatic collect();
    int k;
    words.delete();
    k = 0;
    do begin
      @(posedge i_core_clk);
      k++;
      if (k > 5000) timed_out();
      if (dma_valid === 1'b1 && dma_ready === 1'b1) words.push_back(dma_data);
    end while (k < 4 || dma_busy !== 1'b0 || dma_valid !== 1'b0);
  endtask
  task automatic t_dma();
    slow <= 1'b1;
    bus(1'b1, ADDC_OFS_DESC0, 32'h0000_0402);
    bus(1'b1, ADDC_OFS_DESC1, 32'h0000_1003);
    bus(1'b1, ADDC_OFS_CTRL, 32'h0000_5305);
    collect();
    chk(words.size(), 11);
    chk(words[0], ADDC_META_TAG | 32'h5);
    chk(words[2], 32'h2);
    chk(words[5], ADDC_META_TAG | 32'h5);
    chk(words[7], 32'h3);
    $display("test dma done");
  endtask
  // Gate length sets the transfer length
  task automatic t_gate();
    int n;
    n = 0;
    slow <= 1'b0;
    bus(1'b1, ADDC_OFS_DESC0, ADDC_DESC_RST);
    bus(1'b1, ADDC_OFS_CTRL, 32'h0000_5385);
    i_gate <= 1'b1;
    for (int c = 0; c < 30; c++) begin
      @(posedge i_core_clk);
      if (d0_v === 1'b1) n++;
    end
    i_gate <= 1'b0;
    collect();
    chk(words.size(), n + 3);
    chk(words[2], n);
    $display("test gate done");
  endtask
  // Capture keeps only the first gate after arming; nothing outside a gate
  task automatic t_capture();
    int n;
    n = 0;
    bus(1'b1, ADDC_OFS_CTRL, 32'h0000_0041);
    rchk(ADDC_OFS_STATUS, 32'h0);
    i_gate <= 1'b1;
    for (int c = 0; c < 20; c++) begin
      @(posedge i_core_clk);
      if (d0_v === 1'b1) n++;
    end
    i_gate <= 1'b0;
    repeat (2) @(posedge i_core_clk);
    i_gate <= 1'b1;
    repeat (20) @(posedge i_core_clk);
    i_gate <= 1'b0;
    repeat (2) @(posedge i_core_clk);
    rchk(ADDC_OFS_STATUS, (n << 21) | 32'h0001_8000);
    $display("test capture done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    t_regs();
    t_decim();
    t_route();
    t_coef();
    t_dma();
    t_gate();
    t_capture();
    stop_test();
  end
endmodule // adc_acquisition_ddc_bench

/* verification/addc_far_model.sv */
`timescale 1ns/1ps
// Upstream converters and host sink; the host can stall to test back-pressure
module addc_far_model (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_slow,
  input wire logic [11:0] i_lvl0,
  input wire logic [11:0] i_lvl1,
  output logic [11:0] o_adc0_data,
  output logic [11:0] o_adc1_data,
  output logic o_dma_ready
);
  logic [1:0] cnt_reg;
  ////////////////////////////////////////////////////////////////////////////////
  // Converters give a steady level, one sample each clock
  always_ff @(posedge i_core_clk) begin
    o_adc0_data <= i_lvl0;
    o_adc1_data <= i_lvl1;
  end
  // Slow host takes only one word in three, so the stream must hold its word
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      cnt_reg <= 2'h0;
      o_dma_ready <= 1'b0;
    end else begin
      cnt_reg <= (cnt_reg == 2'h2) ? 2'h0 : cnt_reg + 2'h1;
      o_dma_ready <= !i_slow || (cnt_reg == 2'h0);
    end
  end
endmodule // addc_far_model
